// File: src/afc_avg.sv
// Running average filter for one sampled analog channel.
// Assumes one new sample per sample strobe, signed data.
`timescale 1ns/1ns
module afc_avg #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Sample stream
  input wire logic sample_valid,
  input wire logic signed [W-1:0] sample,
  // Window length, 1..30
  input wire logic [4:0] length,
  // Filtered value
  output logic signed [W-1:0] average
);
  localparam int DEPTH = afc_pkg::FILT_DEPTH;
  // History of samples, index 0 newest
  logic signed [W-1:0] hist [DEPTH];
  // Sum over the selected window
  logic signed [W+5:0] sum;

  // Sum headroom is sized for words of 2 to 24 bits
  if (W < 2 || W > 24) begin : gen_bad_width
    $error("afc_avg: unsupported width");
  end

  // Shift register of samples
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) hist[i] <= '0;
    end else if (sample_valid) begin
      hist[0] <= sample;
      for (int i = 1; i < DEPTH; i++) hist[i] <= hist[i-1];
    end
  end

  // Window sum, recomputed each cycle; cheap enough at 32 taps
  always_comb begin
    sum = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (i < int'(length)) sum = sum + (W+6)'(hist[i]);
    end
  end

  // Divide by window length; zero length treated as one
  always_ff @(posedge mclk) begin
    if (reset) begin
      average <= '0;
    end else begin
      average <= W'(sum / $signed({1'b0, (length == 5'h0) ? 5'h1 : length}));
    end
  end
endmodule : afc_avg

// File: src/afc_pkg.sv
// Constants for the analog frequency command selector.
// Assumes the sampled analog words arrive already converted to digital.
// Contract
// R1: Select low takes unipolar voltage input
// R2: Select high takes current loop input
// R3: Analog drives command only at source 01
// R4: One filter setting 1..30 for all
// R5: Bipolar positive forward, negative reverse
// R6: Pair setting 00 current, 01 bipolar
// R7: Trim only modes 01/02, bipolar not main
// R8: Reverse if bipolar main or mode 02
// R9: Unassigned select ignores pair setting
// R10: Unassigned: 00 bipolar, else voltage+current sum
// R11: Unassigned mode 01 bipolar unipolar only
// R12: Trim alone or offset to main
// R13: 10V full span, lower span selectable
// R14: Running average before selection and scaling
package afc_pkg;
  // Frequency source code that selects the analog path
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  // Trim mode codes
  localparam logic [1:0] TRIM_OFF0 = 2'h0;
  localparam logic [1:0] TRIM_FWD = 2'h1;
  localparam logic [1:0] TRIM_REV = 2'h2;
  localparam logic [1:0] TRIM_OFF3 = 2'h3;
  // Input pair codes
  localparam logic [1:0] PAIR_CURRENT = 2'h0;
  localparam logic [1:0] PAIR_BIPOLAR = 2'h1;
  // Filter range
  localparam int FILT_MIN = 1;
  localparam int FILT_MAX = 30;
  localparam logic [4:0] FILT_RESET = 5'h1;
  // Full span in tenths of a volt
  localparam logic [6:0] SPAN_FULL_DV = 7'h64;
  localparam logic [6:0] SPAN_MIN_DV = 7'h01;
  // Window of the running average
  localparam int FILT_DEPTH = 32;
endpackage : afc_pkg

// File: src/afc_scale.sv
// Span scaling of a command word to the full frequency range.
// Assumes input counts where full-scale 10V equals FULL counts.
`timescale 1ns/1ns
module afc_scale #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Value in, span in tenths of a volt
  input wire logic signed [W+1:0] value,
  input wire logic [6:0] span_dv,
  // Scaled and clamped output
  output logic signed [W-1:0] scaled
);
  localparam logic signed [W+9:0] LIM = (W+10)'((1 << (W-1)) - 1);
  // Widened product before division
  logic signed [W+9:0] prod;
  logic signed [W+9:0] quot;
  logic [6:0] span;

  // Product headroom is sized for words of 2 to 24 bits
  if (W < 2 || W > 24) begin : gen_bad_width
    $error("afc_scale: unsupported width");
  end

  // Guard against a zero or out of range span
  always_comb begin
    span = span_dv;
    if (span < afc_pkg::SPAN_MIN_DV) span = afc_pkg::SPAN_MIN_DV;
    if (span > afc_pkg::SPAN_FULL_DV) span = afc_pkg::SPAN_FULL_DV;
    prod = (W+10)'(value) * $signed({1'b0, afc_pkg::SPAN_FULL_DV});
    quot = prod / $signed({1'b0, span});
  end

  // Clamp to the output range, registered
  always_ff @(posedge mclk) begin
    if (reset) begin
      scaled <= '0;
    end else if (quot > LIM) begin
      scaled <= W'(LIM);
    end else if (quot < -LIM) begin
      scaled <= W'(-LIM);
    end else begin
      scaled <= W'(quot); // R13
    end
  end
endmodule : afc_scale

// File: src/afc_select.sv
// Analog frequency command selection: filter, select, sum, trim, scale.
// Assumes one clock, synchronous settings, and sampled inputs where
// a full-span 10V (or 20mA) input equals the largest positive word.
`timescale 1ns/1ns
module afc_select #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Sampled analog inputs
  input wire logic sample_valid,
  input wire logic signed [W-1:0] unipolar_voltage_input,
  input wire logic signed [W-1:0] current_loop_input,
  input wire logic signed [W-1:0] bipolar_voltage_input,
  // Select terminal and its assignment
  input wire logic analog_type_select,
  input wire logic select_assigned,
  // Settings
  input wire logic [1:0] frequency_source_setting,
  input wire logic [4:0] input_filter_setting,
  input wire logic [1:0] trim_mode_setting,
  input wire logic [1:0] input_pair_setting,
  input wire logic [6:0] full_scale_voltage_setting,
  // Command out
  output logic cmd_valid,
  output logic [W-2:0] freq_cmd,
  output logic cmd_reverse,
  // Status
  output logic trim_enabled,
  output logic reverse_allowed
);
  // Filtered channels
  logic signed [W-1:0] filt [3];
  logic signed [W-1:0] raw [3];
  // Filter length held in range
  logic [4:0] filt_len;
  // Main and trim choice
  logic signed [W+1:0] main_val;
  logic signed [W+1:0] next_sum;
  logic next_trim;
  logic next_rev;
  logic bip_main;
  logic signed [W-1:0] scaled;
  logic analog_src;

  // Narrow words leave no room for the sums; wide ones overflow scaling
  if (W < 4 || W > 24) begin : gen_bad_width
    $error("afc_select: unsupported width");
  end

  assign raw[0] = unipolar_voltage_input;
  assign raw[1] = current_loop_input;
  assign raw[2] = bipolar_voltage_input;

  // Clamp the filter setting to its legal span
  always_ff @(posedge mclk) begin
    if (reset) begin
      filt_len <= afc_pkg::FILT_RESET;
    end else if (input_filter_setting < 5'(afc_pkg::FILT_MIN)) begin
      filt_len <= 5'(afc_pkg::FILT_MIN); // R4
    end else if (input_filter_setting > 5'(afc_pkg::FILT_MAX)) begin
      filt_len <= 5'(afc_pkg::FILT_MAX); // R4
    end else begin
      filt_len <= input_filter_setting;
    end
  end

  // Same filter on every channel, ahead of any selection
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_filt
      afc_avg #(.W(W)) u_avg ( // R4 R14
        .mclk(mclk),
        .reset(reset),
        .sample_valid(sample_valid),
        .sample(raw[g]),
        .length(filt_len),
        .average(filt[g])
      );
    end
  endgenerate

  // Selection table; unipolar inputs never go below zero
  always_comb begin
    logic signed [W+1:0] uv;
    logic signed [W+1:0] ci;
    logic signed [W+1:0] bv;
    uv = (filt[0] < 0) ? '0 : (W+2)'(filt[0]);
    ci = (filt[1] < 0) ? '0 : (W+2)'(filt[1]);
    bv = (W+2)'(filt[2]);
    main_val = uv; // R1
    bip_main = 1'b0;
    next_trim = 1'b0;
    next_rev = 1'b0;
    if (select_assigned) begin
      if (analog_type_select) begin
        if (input_pair_setting == afc_pkg::PAIR_BIPOLAR) begin
          main_val = bv; // R6
          bip_main = 1'b1;
        end else begin
          main_val = ci; // R2 R6
        end
      end
      // Trim for modes 01 and 02 unless bipolar is main
      next_trim = !bip_main && // R7
        (trim_mode_setting == afc_pkg::TRIM_FWD ||
         trim_mode_setting == afc_pkg::TRIM_REV);
      next_rev = bip_main || // R8
        trim_mode_setting == afc_pkg::TRIM_REV;
    end else begin
      // Pair setting not consulted on this path
      case (trim_mode_setting) // R9 R10
        afc_pkg::TRIM_OFF0: begin
          main_val = bv;
          bip_main = 1'b1;
          next_rev = 1'b1;
        end
        afc_pkg::TRIM_FWD: begin
          main_val = uv + ci;
          next_trim = 1'b1; // R11
        end
        afc_pkg::TRIM_REV: begin
          main_val = uv + ci;
          next_trim = 1'b1;
          next_rev = 1'b1;
        end
        default: begin
          main_val = uv + ci;
        end
      endcase
    end
    // Trim acts as offset to the main value, or alone when main is zero
    next_sum = next_trim ? main_val + bv : main_val; // R12
  end

  assign analog_src = frequency_source_setting == afc_pkg::SRC_ANALOG;

  // Span scaling after summation
  afc_scale #(.W(W)) u_scale (
    .mclk(mclk),
    .reset(reset),
    .value(next_sum),
    .span_dv(full_scale_voltage_setting),
    .scaled(scaled)
  );

  // Status flags, registered to align with the scaled value
  always_ff @(posedge mclk) begin
    if (reset) begin
      trim_enabled <= 1'b0;
      reverse_allowed <= 1'b0;
    end else begin
      trim_enabled <= next_trim;
      reverse_allowed <= next_rev;
    end
  end

  // Command output; sign gives direction only when reverse allowed
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_valid <= 1'b0;
      freq_cmd <= '0;
      cmd_reverse <= 1'b0;
    end else if (!analog_src) begin
      cmd_valid <= 1'b0; // R3
      freq_cmd <= '0;
      cmd_reverse <= 1'b0;
    end else if (scaled < 0) begin
      cmd_valid <= 1'b1;
      // Negative with no reverse clamps to zero, never flips direction
      freq_cmd <= reverse_allowed ? (W-1)'(-scaled) : '0; // R5 R8
      cmd_reverse <= reverse_allowed; // R5
    end else begin
      cmd_valid <= 1'b1;
      freq_cmd <= (W-1)'(scaled);
      cmd_reverse <= 1'b0; // R5
    end
  end

  // Assertions
  AST_SOURCE_GATE: assert property (@(posedge mclk) disable iff (reset) // R3
    !analog_src |=> !cmd_valid && freq_cmd == '0)
    else $error("command active without analog source");
  AST_FILT_RANGE: assert property (@(posedge mclk) disable iff (reset) // R4
    ##1 filt_len >= 5'(afc_pkg::FILT_MIN) && filt_len <= 5'(afc_pkg::FILT_MAX))
    else $error("filter length out of range");
  AST_FWD_ONLY: assert property (@(posedge mclk) disable iff (reset) // R8
    cmd_reverse |-> $past(reverse_allowed))
    else $error("reverse without permission");
  AST_TRIM_BIP: assert property (@(posedge mclk) disable iff (reset) // R7
    select_assigned && analog_type_select &&
    input_pair_setting == afc_pkg::PAIR_BIPOLAR |=> !trim_enabled)
    else $error("trim enabled with bipolar main");
  AST_TRIM_OFF: assert property (@(posedge mclk) disable iff (reset) // R7
    select_assigned && (trim_mode_setting == afc_pkg::TRIM_OFF0 ||
    trim_mode_setting == afc_pkg::TRIM_OFF3) |=> !trim_enabled)
    else $error("trim enabled in off mode");
  AST_REV_MODE2: assert property (@(posedge mclk) disable iff (reset) // R8
    trim_mode_setting == afc_pkg::TRIM_REV |=> reverse_allowed)
    else $error("mode 02 without reverse");
  AST_UNASSIGNED_0: assert property (@(posedge mclk) disable iff (reset) // R10
    !select_assigned && trim_mode_setting == afc_pkg::TRIM_OFF0
    |=> reverse_allowed && !trim_enabled)
    else $error("unassigned mode 00 wrong");
  AST_UNASSIGNED_1: assert property (@(posedge mclk) disable iff (reset) // R11
    !select_assigned && trim_mode_setting == afc_pkg::TRIM_FWD
    |=> !reverse_allowed && trim_enabled)
    else $error("unassigned mode 01 wrong");
  AST_NEG_CLAMP: assert property (@(posedge mclk) disable iff (reset) // R5
    analog_src && scaled < 0 && !reverse_allowed |=> freq_cmd == '0)
    else $error("negative command passed forward");

  // Command word limit, for the span checks below
  localparam logic signed [W+1:0] CMD_MAX = (W+2)'((1 << (W-1)) - 1);

  // Analog source always yields a live command one edge later
  AST_VALID_SRC: assert property (@(posedge mclk) disable iff (reset) // R3
    analog_src |=> cmd_valid)
    else $error("command idle with analog source");

  // Settings above the window top are held at the top
  AST_FILT_HIGH: assert property (@(posedge mclk) disable iff (reset) // R4
    input_filter_setting > 5'(afc_pkg::FILT_MAX)
    |=> filt_len == 5'(afc_pkg::FILT_MAX))
    else $error("filter setting above range not clamped");

  // A zero setting still averages one sample
  AST_FILT_LOW: assert property (@(posedge mclk) disable iff (reset) // R4
    input_filter_setting < 5'(afc_pkg::FILT_MIN)
    |=> filt_len == 5'(afc_pkg::FILT_MIN))
    else $error("filter setting below range not clamped");

  // In-range settings pass through unchanged
  AST_FILT_PASS: assert property (@(posedge mclk) disable iff (reset) // R4
    input_filter_setting >= 5'(afc_pkg::FILT_MIN) &&
    input_filter_setting <= 5'(afc_pkg::FILT_MAX)
    |=> filt_len == $past(input_filter_setting))
    else $error("filter setting not taken");

  // Unit window: the average is the sample taken two edges back
  AST_FILT_UNIT: assert property (@(posedge mclk) disable iff (reset) // R14
    sample_valid && filt_len == 5'h1 ##1 filt_len == 5'h1
    |=> filt[0] == $past(unipolar_voltage_input, 2))
    else $error("unit window average wrong");

  // Trim opens in modes 01 and 02 while bipolar is not main
  AST_TRIM_ON: assert property (@(posedge mclk) disable iff (reset) // R7
    select_assigned && !(analog_type_select &&
    input_pair_setting == afc_pkg::PAIR_BIPOLAR) &&
    (trim_mode_setting == afc_pkg::TRIM_FWD ||
    trim_mode_setting == afc_pkg::TRIM_REV) |=> trim_enabled)
    else $error("trim blocked in a trim mode");

  // Bipolar main always permits reverse
  AST_REV_BIP: assert property (@(posedge mclk) disable iff (reset) // R8
    select_assigned && analog_type_select &&
    input_pair_setting == afc_pkg::PAIR_BIPOLAR |=> reverse_allowed)
    else $error("bipolar main without reverse");

  // Other assigned paths stay forward-only outside mode 02
  AST_FWD_ASG: assert property (@(posedge mclk) disable iff (reset) // R8
    select_assigned && trim_mode_setting != afc_pkg::TRIM_REV &&
    !(analog_type_select && input_pair_setting == afc_pkg::PAIR_BIPOLAR)
    |=> !reverse_allowed)
    else $error("reverse allowed on a forward-only path");

  // Unassigned mode 02: sum with trim, reverse allowed
  AST_UNASSIGNED_2: assert property (@(posedge mclk) disable iff (reset) // R10
    !select_assigned && trim_mode_setting == afc_pkg::TRIM_REV
    |=> reverse_allowed && trim_enabled)
    else $error("unassigned mode 02 wrong");

  // Unassigned mode 03: sum only, no trim, no reverse
  AST_UNASSIGNED_3: assert property (@(posedge mclk) disable iff (reset) // R10
    !select_assigned && trim_mode_setting == afc_pkg::TRIM_OFF3
    |=> !reverse_allowed && !trim_enabled)
    else $error("unassigned mode 03 wrong");

  // Full 10V span maps the summed value one to one
  AST_SPAN_FULL: assert property (@(posedge mclk) disable iff (reset) // R13
    full_scale_voltage_setting == afc_pkg::SPAN_FULL_DV &&
    next_sum <= CMD_MAX && next_sum >= -CMD_MAX
    |=> scaled == W'($past(next_sum)))
    else $error("full span scaling wrong");

  // Half span doubles the value, within the output range
  AST_SPAN_HALF: assert property (@(posedge mclk) disable iff (reset) // R13
    full_scale_voltage_setting == (afc_pkg::SPAN_FULL_DV >> 1) &&
    next_sum <= (CMD_MAX >>> 1) && next_sum >= -(CMD_MAX >>> 1)
    |=> scaled == W'($past(next_sum) * 2))
    else $error("half span scaling wrong");

  // Half span past the range pins the command at its top
  AST_SPAN_CLAMP: assert property (@(posedge mclk) disable iff (reset) // R13
    full_scale_voltage_setting == (afc_pkg::SPAN_FULL_DV >> 1) &&
    next_sum > (CMD_MAX >>> 1) |=> scaled == W'(CMD_MAX))
    else $error("scaled command not clamped");

  // Positive values command forward with the scaled magnitude
  AST_FWD_PASS: assert property (@(posedge mclk) disable iff (reset) // R5
    analog_src && !scaled[W-1]
    |=> !cmd_reverse && freq_cmd == (W-1)'($past(scaled)))
    else $error("forward command wrong");

  // Negative values with reverse allowed command reverse
  AST_REV_PASS: assert property (@(posedge mclk) disable iff (reset) // R5
    analog_src && scaled[W-1] && reverse_allowed
    |=> cmd_reverse && freq_cmd == (W-1)'(-$past(scaled)))
    else $error("reverse command wrong");
endmodule : afc_select

// File: tb/afc_source.sv
// Analog source model: three sampled channels from set levels.
// Assumes the bench sets levels and pace; one sample per valid cycle.
`timescale 1ns/1ns
module afc_source (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pace and levels from the bench
  input wire logic slow,
  input wire logic signed [11:0] u_lvl,
  input wire logic signed [11:0] c_lvl,
  input wire logic signed [11:0] b_lvl,
  // Sample stream
  output logic sample_valid,
  output logic signed [11:0] u_out,
  output logic signed [11:0] c_out,
  output logic signed [11:0] b_out
);
  logic next_valid; // Valid for the coming cycle

  // Slow pace samples every other cycle
  always_comb begin
    next_valid = slow ? ~sample_valid : 1'b1;
  end

  // Off cycles carry inverted words so stale data cannot pass
  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= next_valid;
    end
    u_out <= next_valid ? u_lvl : ~u_lvl;
    c_out <= next_valid ? c_lvl : ~c_lvl;
    b_out <= next_valid ? b_lvl : ~b_lvl;
  end
endmodule : afc_source

// File: tb/analog_frequency_command_select_tb.sv
// Self-checking bench for the analog command selector.
// Assumes W of 12 and settled outputs 80 cycles after a change.
`timescale 1ns/1ns
module analog_frequency_command_select_tb;
  localparam int W = 12;
  logic mclk, reset, slow, sel, asg, sample_valid;
  logic signed [W-1:0] u_lvl, c_lvl, b_lvl, u_in, c_in, b_in;
  logic [1:0] src, mode, pair;
  logic [4:0] filt;
  logic [6:0] span;
  logic cmd_valid, cmd_reverse, trim_enabled, reverse_allowed;
  logic [W-2:0] freq_cmd;
  int error_cnt, comparisons;

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  afc_source src_model (.mclk(mclk), .reset(reset), .slow(slow),
    .u_lvl(u_lvl), .c_lvl(c_lvl), .b_lvl(b_lvl),
    .sample_valid(sample_valid), .u_out(u_in), .c_out(c_in), .b_out(b_in));

  afc_select #(.W(W)) uut (.mclk(mclk), .reset(reset),
    .sample_valid(sample_valid), .unipolar_voltage_input(u_in),
    .current_loop_input(c_in), .bipolar_voltage_input(b_in),
    .analog_type_select(sel), .select_assigned(asg),
    .frequency_source_setting(src), .input_filter_setting(filt),
    .trim_mode_setting(mode), .input_pair_setting(pair),
    .full_scale_voltage_setting(span), .cmd_valid(cmd_valid),
    .freq_cmd(freq_cmd), .cmd_reverse(cmd_reverse),
    .trim_enabled(trim_enabled), .reverse_allowed(reverse_allowed));

  // Verdict and end of run
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // Wait, then step past the edge so outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic drive(input logic a, s, input logic [1:0] m, p,
                       input int uu, cc, bb, sp);
    @(posedge mclk);
    asg <= a;
    sel <= s;
    mode <= m;
    pair <= p;
    u_lvl <= uu[W-1:0];
    c_lvl <= cc[W-1:0];
    b_lvl <= bb[W-1:0];
    span <= sp[6:0];
  endtask : drive

  // Expected command worked out from the present settings
  task automatic check();
    int mv, v, q, ec, uv, cv;
    logic tr, rv, bm;
    // Unipolar inputs read negative levels as zero
    uv = (u_lvl < 0) ? 0 : int'(u_lvl);
    cv = (c_lvl < 0) ? 0 : int'(c_lvl);
    bm = asg && sel && pair == 2'h1;
    if (asg) begin
      mv = !sel ? uv : (bm ? int'(b_lvl) : cv);
      tr = (mode == 2'h1 || mode == 2'h2) && !bm;
      rv = bm || mode == 2'h2;
    end else if (mode == 2'h0) begin
      mv = int'(b_lvl);
      tr = 1'b0;
      rv = 1'b1;
    end else begin
      mv = uv + cv;
      tr = mode != 2'h3;
      rv = mode == 2'h2;
    end
    v = mv + (tr ? int'(b_lvl) : 0);
    q = v * 100 / int'(span);
    if (q > 2047) q = 2047;
    if (q < -2047) q = -2047;
    ec = (q >= 0) ? q : (rv ? -q : 0);
    compare(cmd_valid, 1);
    compare(trim_enabled, tr);
    compare(reverse_allowed, rv);
    compare(freq_cmd, ec);
    compare(cmd_reverse, q < 0 && rv);
  endtask : check

  task automatic run_case(input logic a, s, input logic [1:0] m, p,
                          input int uu, cc, bb, sp);
    drive(a, s, m, p, uu, cc, bb, sp);
    settle(80);
    check();
  endtask : run_case

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    slow = 1'b0;
    sel = 1'b0;
    asg = 1'b1;
    src = 2'h1;
    filt = 5'h1;
    mode = 2'h0;
    pair = 2'h0;
    span = 7'h64;
    u_lvl = '0;
    c_lvl = '0;
    b_lvl = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    // Every select and mode, pair 00 and 01, with trim both ways
    for (int i = 0; i < 64; i++) begin
      run_case(i[0], i[1], i[3:2], {1'b0, i[4]}, 600, 300,
               i[5] ? 500 : -200, 100);
    end
    run_case(0, 0, 2'h1, 2'h0, 0, 0, -500, 100);
    run_case(0, 0, 2'h2, 2'h0, 0, 0, -500, 100);
    run_case(1, 0, 2'h0, 2'h0, 1000, 0, 0, 50);
    run_case(1, 0, 2'h0, 2'h0, 1500, 0, 0, 50);
    // Negative unipolar reads as zero; pair code 10 picks current
    run_case(0, 0, 2'h2, 2'h0, -400, 700, 0, 100);
    run_case(1, 1, 2'h3, 2'h2, 0, 800, 500, 100);
    // Gaps between samples must not disturb the command
    @(posedge mclk);
    slow <= 1'b1;
    run_case(1, 1, 2'h1, 2'h0, 0, 700, 100, 100);
    // Non-analog source drops the command
    @(posedge mclk);
    slow <= 1'b0;
    src <= 2'h0;
    settle(10);
    compare(cmd_valid, 0);
    compare(freq_cmd, 0);
    @(posedge mclk);
    src <= 2'h1;
    // Long window rises slowly to the step value
    filt <= 5'h1e;
    run_case(1, 0, 2'h0, 2'h0, 0, 0, 0, 100);
    drive(1, 0, 2'h0, 2'h0, 300, 0, 0, 100);
    settle(12);
    compare(freq_cmd > 0 && freq_cmd < 300, 1);
    settle(60);
    check();
    // Settings outside 1..30 are clamped; a steady input keeps its value
    @(posedge mclk);
    filt <= 5'h1f;
    settle(4);
    @(posedge mclk);
    filt <= 5'h00;
    settle(4);
    check();
    @(posedge mclk);
    filt <= 5'h1e;
    // Mid-run reset clears the history, so the long window refills
    @(posedge mclk);
    reset <= 1'b1;
    settle(2);
    compare(freq_cmd, 0);
    @(posedge mclk);
    reset <= 1'b0;
    settle(12);
    compare(freq_cmd > 0 && freq_cmd < 300, 1);
    settle(60);
    check();
    results();
  end
endmodule : analog_frequency_command_select_tb
